// ===== shared/pwm_seq_pkg.sv
package pwm_seq_pkg;

  localparam int CMP_W = 15;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 32;
  localparam int LEN_W = 15;
  localparam int REFRESH_W = 24;
  localparam int CHANNELS = 4;
  localparam int POL_BIT = 15;
  localparam logic [ADDR_W-1:0] WORD_BYTES = 32'h0000_0002;
  localparam int WAVE_TOP_SLOT = 3;
  localparam int WAVE_LAST_CH = 2;
  localparam logic [2:0] WPS_COMMON = 3'h1;
  localparam logic [2:0] WPS_GROUPED = 3'h2;
  localparam logic [2:0] WPS_INDIVIDUAL = 3'h4;
  localparam logic [2:0] WPS_WAVE = 3'h4;
  localparam logic [CMP_W-1:0] TOP_RESET = 15'h03E8;
  localparam logic [3:0] IDLE_PINS_RESET = 4'h0;

  typedef enum logic [1:0] {
    LAYOUT_COMMON = 2'h0,
    LAYOUT_GROUPED = 2'h1,
    LAYOUT_INDIVIDUAL = 2'h2,
    WAVE_LAYOUT = 2'h3
  } layout_t;

  typedef struct packed {
    logic pol;
    logic [CMP_W-1:0] val;
  } cmp_t;

  typedef struct packed {
    logic [ADDR_W-1:0] sequence_base;
    logic [LEN_W-1:0] sequence_length;
    logic [REFRESH_W-1:0] refresh;
  } seq_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRIME = 3'b010,
    ST_RUN = 3'b100
  } gen_state_t;

endpackage : pwm_seq_pkg

// ===== src/seq_fifo.sv
`timescale 1ns/100ps
module seq_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
    $error("seq_fifo needs DEPTH >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] rd_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  assign in_ready_o = (count_r != FULL);
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem[rd_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_r] <= in_data_i;
    end
  end

  // pointers wrap by compare so any depth works, not only powers of two
  always_ff @(posedge clock_i) begin
    if (srst_i || flush_i) begin
      wr_r <= '0;
      rd_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : seq_fifo

// ===== src/period_pacer.sv
`timescale 1ns/100ps
module period_pacer #(
  parameter int W = 24
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic [W-1:0] limit_i,
  output logic due_o
);
  if (W < 1) begin : g_bad_param
    $error("period_pacer needs W >= 1");
  end

  logic [W-1:0] cnt_r;

  // due on the (limit+1)th period end since the last load
  assign due_o = (cnt_r >= limit_i);

  always_ff @(posedge clock_i) begin
    if (srst_i || clear_i) begin
      cnt_r <= '0;
    end else if (tick_i && !(&cnt_r)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule : period_pacer

// ===== src/pwm_sequence_decoder_dma.sv
// Function
// - sequence word: bit 15 is polarity, bits 14:0 the compare value
// - polarity 0 makes the first edge rise, 1 makes it fall
// - layout picks common, grouped or per-channel loading of compare values
// - wave layout drives only outputs zero to two
// - wave layout takes four words per step, the fourth is the period top
// - refresh count N applies a new value every (N+1)th period
// - refresh count zero applies a new value every period
// - manual advance mode ignores refresh, loads on each advance task
// - grouped takes one word per group, individual one per channel
// - begin while idle fetches first value before generation starts
// - begun event once first word read and counter runs with it
// - sequence is played exactly once, no chaining
// - done event when last word is loaded and starts executing
// - after the end keep generating with the last loaded values
// - stop accepted while not idle, halts at period end (at once while priming), event, idle pins
// - after stop only a begin task restarts, after first fetch
// - base and length captured when the begin task arrives
// - counter wraps to zero at the period top and outputs toggle
// - outside wave layout the new top applies at period end
`timescale 1ns/100ps
module pwm_sequence_decoder_dma #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [1:0] sequence_begin_task_i,
  input wire logic advance_task_i,
  input wire logic stop_task_i,
  input wire pwm_seq_pkg::layout_t load_layout_i,
  input wire logic manual_advance_mode_i,
  input wire pwm_seq_pkg::seq_cfg_t seq0_cfg_i,
  input wire pwm_seq_pkg::seq_cfg_t seq1_cfg_i,
  input wire logic [pwm_seq_pkg::CMP_W-1:0] period_top_i,
  input wire logic [pwm_seq_pkg::CHANNELS-1:0] idle_level_i,
  output logic rd_req_o,
  output logic [pwm_seq_pkg::ADDR_W-1:0] rd_addr_o,
  input wire logic rd_ack_i,
  input wire logic rd_valid_i,
  input wire logic [pwm_seq_pkg::WORD_W-1:0] rd_data_i,
  output logic [pwm_seq_pkg::CHANNELS-1:0] pwm_o,
  output logic running_o,
  output logic [1:0] sequence_begun_event_o,
  output logic [1:0] sequence_done_event_o,
  output logic period_end_event_o,
  output logic stopped_event_o
);
  import pwm_seq_pkg::*;

  if (FIFO_DEPTH < 4) begin : g_bad_param
    $error("FIFO_DEPTH must hold at least one step of four words");
  end

  gen_state_t state_r;
  logic seq_sel_r;
  logic [ADDR_W-1:0] base_r;
  logic [LEN_W-1:0] len_r;
  logic [LEN_W-1:0] fetch_idx_r;
  logic [LEN_W-1:0] popped_r;
  logic rd_req_r;
  logic pend_r;
  logic discard_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic [WORD_W-1:0] stage_r [CHANNELS];
  logic [2:0] stage_cnt_r;
  cmp_t cmp_r [CHANNELS];
  logic [CMP_W-1:0] top_r;
  logic [CMP_W-1:0] cnt_r;
  logic first_r;
  logic adv_pend_r;
  logic stop_pend_r;
  logic [CHANNELS-1:0] pwm_r;
  logic running_r;
  logic [1:0] begun_r;
  logic [1:0] done_r;
  logic period_end_r;
  logic stopped_r;

  logic begin_task;
  logic begin_sel;
  seq_cfg_t begin_cfg;
  logic [2:0] wps;
  logic step_ready;
  logic last_step;
  logic period_end;
  logic pacer_due;
  logic due;
  logic apply;
  logic halt;
  logic flush;
  logic issue;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic pop;
  logic [REFRESH_W-1:0] refresh_sel;

  // sequence 0 wins if both begin tasks arrive together
  assign begin_sel = !sequence_begin_task_i[0];
  assign begin_cfg = begin_sel ? seq1_cfg_i : seq0_cfg_i;
  // an empty sequence has nothing to play, so its begin task is dropped
  assign begin_task = (|sequence_begin_task_i) && (begin_cfg.sequence_length != '0);
  assign refresh_sel = seq_sel_r ? seq1_cfg_i.refresh : seq0_cfg_i.refresh;

  always_comb begin
    case (load_layout_i)
      LAYOUT_COMMON: wps = WPS_COMMON;
      LAYOUT_GROUPED: wps = WPS_GROUPED;
      LAYOUT_INDIVIDUAL: wps = WPS_INDIVIDUAL;
      WAVE_LAYOUT: wps = WPS_WAVE;
      default: wps = WPS_COMMON;
    endcase
  end

  // a short tail still forms a step; unfilled slots keep their old values
  assign step_ready = (stage_cnt_r == wps) || (stage_cnt_r != '0 && popped_r == len_r);
  assign last_step = (popped_r == len_r);
  assign period_end = (state_r == ST_RUN) && ({1'b0, cnt_r} + 16'h0001 >= {1'b0, top_r});
  assign due = manual_advance_mode_i ? adv_pend_r : pacer_due;
  assign apply = step_ready && !begin_task &&
    ((state_r == ST_PRIME) || (period_end && due && !stop_pend_r));
  assign halt = (stop_pend_r || stop_task_i) && !begin_task &&
    ((state_r == ST_PRIME) || period_end);
  assign flush = begin_task || halt;
  assign pop = fifo_out_valid && (stage_cnt_r < wps) && !step_ready && !flush;
  // one read in flight at most, so a granted slot is always free on return
  assign issue = (state_r != ST_IDLE) && (fetch_idx_r != len_r) && !rd_req_r &&
    !pend_r && fifo_in_ready && !flush;

  period_pacer #(
    .W(REFRESH_W)
  ) u_pacer (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .tick_i(period_end),
    .clear_i(apply || flush),
    .limit_i(refresh_sel),
    .due_o(pacer_due)
  );

  seq_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .flush_i(flush),
    .in_valid_i(rd_valid_i && !discard_r),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rd_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out_data)
  );

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_r <= ST_IDLE;
    end else if (begin_task) begin
      state_r <= (state_r == ST_RUN) ? ST_RUN : ST_PRIME;
    end else if (halt) begin
      state_r <= ST_IDLE;
    end else if (apply && state_r == ST_PRIME) begin
      state_r <= ST_RUN;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      seq_sel_r <= 1'b0;
      base_r <= '0;
      len_r <= '0;
    end else if (begin_task) begin
      seq_sel_r <= begin_sel;
      base_r <= begin_cfg.sequence_base;
      len_r <= begin_cfg.sequence_length;
    end
  end

  // read master: request held until acknowledged, data returns later
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rd_req_r <= 1'b0;
      pend_r <= 1'b0;
      discard_r <= 1'b0;
      rd_addr_r <= '0;
      fetch_idx_r <= '0;
    end else begin
      if (flush) begin
        fetch_idx_r <= '0;
      end else if (issue) begin
        fetch_idx_r <= fetch_idx_r + 1'b1;
      end
      if (issue) begin
        rd_req_r <= 1'b1;
        rd_addr_r <= base_r + ADDR_W'(fetch_idx_r) * WORD_BYTES;
      end else if (rd_req_r && rd_ack_i) begin
        rd_req_r <= 1'b0;
      end
      if (rd_req_r && rd_ack_i) begin
        pend_r <= 1'b1;
      end else if (rd_valid_i) begin
        pend_r <= 1'b0;
      end
      // a read already on the bus at restart is completed and thrown away
      if (flush && (rd_req_r || pend_r)) begin
        discard_r <= 1'b1;
      end else if (rd_valid_i) begin
        discard_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || flush) begin
      stage_cnt_r <= '0;
      popped_r <= '0;
    end else begin
      if (pop) begin
        stage_r[stage_cnt_r[1:0]] <= fifo_out_data;
        popped_r <= popped_r + 1'b1;
      end
      if (apply) begin
        stage_cnt_r <= '0;
      end else if (pop) begin
        stage_cnt_r <= stage_cnt_r + 1'b1;
      end
    end
  end

  // compare values only change at period end or before the counter runs
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        cmp_r[i] <= '0;
      end
    end else if (apply) begin
      for (int i = 0; i < CHANNELS; i++) begin
        logic [2:0] src;
        src = 3'h0;
        case (load_layout_i)
          LAYOUT_COMMON: src = 3'h0;
          LAYOUT_GROUPED: src = 3'(i / 2);
          default: src = 3'(i);
        endcase
        if (src < stage_cnt_r && !(load_layout_i == WAVE_LAYOUT && i > WAVE_LAST_CH)) begin
          cmp_r[i] <= '{pol: stage_r[src[1:0]][POL_BIT],
                        val: stage_r[src[1:0]][CMP_W-1:0]};
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      top_r <= TOP_RESET;
    end else if (apply && load_layout_i == WAVE_LAYOUT) begin
      if (stage_cnt_r == WPS_WAVE) begin
        top_r <= stage_r[WAVE_TOP_SLOT][CMP_W-1:0];
      end
    end else if (load_layout_i != WAVE_LAYOUT && (period_end || apply)) begin
      top_r <= period_top_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || state_r != ST_RUN) begin
      cnt_r <= '0;
    end else if (period_end) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      first_r <= 1'b0;
      adv_pend_r <= 1'b0;
      stop_pend_r <= 1'b0;
    end else begin
      if (begin_task) begin
        first_r <= 1'b1;
      end else if (apply) begin
        first_r <= 1'b0;
      end
      // a task landing with the load that consumes it is kept
      if (advance_task_i && state_r != ST_IDLE) begin
        adv_pend_r <= 1'b1;
      end else if (apply || flush) begin
        adv_pend_r <= 1'b0;
      end
      if (stop_task_i && state_r != ST_IDLE && !halt) begin
        stop_pend_r <= 1'b1;
      end else if (halt || begin_task) begin
        stop_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      begun_r <= '0;
      done_r <= '0;
      period_end_r <= 1'b0;
      stopped_r <= 1'b0;
    end else begin
      begun_r <= (apply && first_r) ? (2'h1 << seq_sel_r) : 2'h0;
      // no chaining: the last step ends playback, later periods reuse it
      done_r <= (apply && last_step) ? (2'h1 << seq_sel_r) : 2'h0;
      period_end_r <= period_end;
      stopped_r <= halt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pwm_r <= IDLE_PINS_RESET;
      running_r <= 1'b0;
    end else begin
      running_r <= (state_r == ST_RUN);
      for (int i = 0; i < CHANNELS; i++) begin
        if (state_r != ST_RUN || (load_layout_i == WAVE_LAYOUT && i > WAVE_LAST_CH)) begin
          pwm_r[i] <= idle_level_i[i];
        end else begin
          pwm_r[i] <= (cnt_r < cmp_r[i].val) ? cmp_r[i].pol : !cmp_r[i].pol;
        end
      end
    end
  end

  assign rd_req_o = rd_req_r;
  assign rd_addr_o = rd_addr_r;
  assign pwm_o = pwm_r;
  assign running_o = running_r;
  assign sequence_begun_event_o = begun_r;
  assign sequence_done_event_o = done_r;
  assign period_end_event_o = period_end_r;
  assign stopped_event_o = stopped_r;
endmodule : pwm_sequence_decoder_dma

// ===== sim/ram_model.sv
`timescale 1ns/100ps
module ram_model
  import pwm_seq_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic slow_i,
  input wire logic rd_req_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic rd_ack_o,
  output logic rd_valid_o,
  output logic [WORD_W-1:0] rd_data_o
);
  // only a small window of ram is mapped; bases must fall inside it
  logic [WORD_W-1:0] mem [0:127];
  logic busy_r;
  logic [2:0] wait_r;
  logic [6:0] idx_r;
  always_ff @(posedge clock_i) begin
    rd_ack_o <= 1'b0;
    rd_valid_o <= 1'b0;
    // data wanders when not valid so a stale sample never matches
    rd_data_o <= ~rd_data_o;
    if (srst_i) begin
      busy_r <= 1'b0;
      rd_data_o <= 16'hA5A5;
    end else if (!busy_r && rd_req_i) begin
      rd_ack_o <= 1'b1;
      busy_r <= 1'b1;
      idx_r <= rd_addr_i[7:1];
      wait_r <= slow_i ? 3'h4 : 3'h1;
    end else if (busy_r && wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end else if (busy_r) begin
      rd_valid_o <= 1'b1;
      rd_data_o <= mem[idx_r];
      busy_r <= 1'b0;
    end
  end
endmodule : ram_model

// ===== sim/pwm_seq_props.sv
`timescale 1ns/100ps
module pwm_seq_props
  import pwm_seq_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [1:0] sequence_begin_task_i,
  input wire logic running_o,
  input wire logic rd_req_o,
  input wire logic [ADDR_W-1:0] rd_addr_o,
  input wire logic rd_ack_i,
  input wire logic rd_valid_i,
  input wire pwm_seq_pkg::layout_t load_layout_i,
  input wire pwm_seq_pkg::seq_cfg_t seq0_cfg_i,
  input wire pwm_seq_pkg::seq_cfg_t seq1_cfg_i,
  input wire logic [CHANNELS-1:0] idle_level_i,
  input wire logic [CHANNELS-1:0] pwm_o,
  input wire logic [1:0] sequence_begun_event_o,
  input wire logic [1:0] sequence_done_event_o,
  input wire logic period_end_event_o,
  input wire logic stopped_event_o
);
  logic [ADDR_W-1:0] next_addr_r;
  logic waiting_r;
  logic got_word_r;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  always_ff @(posedge clock_i) begin
    if (sequence_begin_task_i[0]) next_addr_r <= seq0_cfg_i.sequence_base;
    else if (sequence_begin_task_i[1]) next_addr_r <= seq1_cfg_i.sequence_base;
    else if (rd_req_o && rd_ack_i) next_addr_r <= next_addr_r + WORD_BYTES;
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) waiting_r <= 1'b0;
    else if (rd_req_o && rd_ack_i) waiting_r <= 1'b1;
    else if (rd_valid_i) waiting_r <= 1'b0;
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) got_word_r <= 1'b0;
    else if (rd_valid_i) got_word_r <= 1'b1;
    else if (|sequence_begin_task_i && !running_o) got_word_r <= 1'b0;
  end
  property p_req_hold;
    rd_req_o && !rd_ack_i |=> rd_req_o && $stable(rd_addr_o);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("read request dropped early");
  property p_addr_seq;
    rd_req_o |-> rd_addr_o == next_addr_r;
  endproperty
  a_addr_seq: assert property (p_addr_seq) else $error("read address out of order");
  property p_one_out;
    waiting_r |-> !rd_req_o;
  endproperty
  a_one_out: assert property (p_one_out) else $error("second read while one open");
  // running follows the state register, so it trails the begun pulse by a cycle
  property p_begun_run;
    $rose(running_o) |-> $past(sequence_begun_event_o) != 2'h0;
  endproperty
  a_begun_run: assert property (p_begun_run) else $error("run began without event");
  property p_first_fetch;
    $rose(running_o) |-> got_word_r;
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("run before first word");
  property p_stop_idle;
    stopped_event_o |=> pwm_o == idle_level_i;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("pins not idle after stop");
  property p_fell_stop;
    $fell(running_o) |-> $past(stopped_event_o) or (##[0:1] stopped_event_o);
  endproperty
  a_fell_stop: assert property (p_fell_stop) else $error("halt without stop event");
  property p_done_align;
    sequence_done_event_o != 2'h0 |-> (sequence_done_event_o == sequence_begun_event_o
      || period_end_event_o || $past(period_end_event_o)) or (##1 period_end_event_o);
  endproperty
  a_done_align: assert property (p_done_align) else $error("done off period end");
  property p_wave_ch3;
    load_layout_i == WAVE_LAYOUT && running_o && $past(running_o)
      |-> pwm_o[3] == idle_level_i[3];
  endproperty
  a_wave_ch3: assert property (p_wave_ch3) else $error("channel 3 driven in wave");
  c_begun0: cover property (sequence_begun_event_o[0]);
  c_begun1: cover property (sequence_begun_event_o[1]);
  c_done: cover property (sequence_done_event_o != 2'h0);
  c_stop: cover property (stopped_event_o);
endmodule : pwm_seq_props

bind pwm_sequence_decoder_dma pwm_seq_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_pwm_seq_props (
  .clock_i(clock_i), .srst_i(srst_i), .sequence_begin_task_i(sequence_begin_task_i),
  .running_o(running_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_ack_i(rd_ack_i),
  .rd_valid_i(rd_valid_i), .load_layout_i(load_layout_i), .seq0_cfg_i(seq0_cfg_i),
  .seq1_cfg_i(seq1_cfg_i), .idle_level_i(idle_level_i), .pwm_o(pwm_o),
  .sequence_begun_event_o(sequence_begun_event_o), .sequence_done_event_o(sequence_done_event_o),
  .period_end_event_o(period_end_event_o), .stopped_event_o(stopped_event_o));

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import pwm_seq_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0] begin_t = 2'h0;
  logic adv_t = 1'b0;
  logic stop_t = 1'b0;
  layout_t layout = LAYOUT_COMMON;
  logic manual = 1'b0;
  seq_cfg_t cfg0 = '0;
  seq_cfg_t cfg1 = '0;
  logic [CHANNELS-1:0] idle_lv = 4'hA;
  logic slow = 1'b0;
  logic [CMP_W-1:0] top_v = 15'h000A;
  logic rd_req, rd_ack, rd_valid, running, pe, stopped;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_data;
  logic [CHANNELS-1:0] pwm;
  logic [1:0] begun, done;
  logic [WORD_W-1:0] wq [$];
  int failures = 0;
  int comparisons = 0;
  int hi [CHANNELS];
  int plen, n, k, done_cnt = 0;
  always #50 clock_i = ~clock_i;
  always @(negedge clock_i) done_cnt += (done !== 2'h0);
  pwm_sequence_decoder_dma u_pwm_sequence_decoder_dma (.clock_i(clock_i), .srst_i(srst_i),
    .sequence_begin_task_i(begin_t), .advance_task_i(adv_t), .stop_task_i(stop_t),
    .load_layout_i(layout), .manual_advance_mode_i(manual), .seq0_cfg_i(cfg0),
    .seq1_cfg_i(cfg1), .period_top_i(top_v), .idle_level_i(idle_lv), .rd_req_o(rd_req),
    .rd_addr_o(rd_addr), .rd_ack_i(rd_ack), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .pwm_o(pwm), .running_o(running), .sequence_begun_event_o(begun),
    .sequence_done_event_o(done), .period_end_event_o(pe), .stopped_event_o(stopped));
  ram_model u_ram_model (.clock_i(clock_i), .srst_i(srst_i), .slow_i(slow),
    .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_ack_o(rd_ack), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data));
  task automatic give_verdict;
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // 0 period end, 1 begun, 2 done, 3 stopped
  task automatic wait_sig(input int sel);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clock_i);
      if (sel == 0 && pe === 1'b1 || sel == 1 && begun !== 2'h0) break;
      if (sel == 2 && done !== 2'h0 || sel == 3 && stopped === 1'b1) break;
    end
    if (i == 400) begin
      failures++;
      give_verdict();
    end
  endtask : wait_sig
  // 0 begin sequence s, 1 advance, 2 stop
  task automatic pulse(input int sel, input int s);
    @(negedge clock_i);
    if (sel == 0) begin_t[s] = 1'b1;
    else if (sel == 1) adv_t = 1'b1;
    else stop_t = 1'b1;
    @(negedge clock_i);
    begin_t = 2'h0;
    adv_t = 1'b0;
    stop_t = 1'b0;
  endtask : pulse
  task automatic play(input int s, input layout_t ly, input int rf);
    seq_cfg_t c;
    c.sequence_base = 32'h0000_0040 << s;
    c.sequence_length = LEN_W'(wq.size());
    c.refresh = REFRESH_W'(rf);
    foreach (wq[j]) u_ram_model.mem[c.sequence_base[7:1] + j] = wq[j];
    @(negedge clock_i);
    layout = ly;
    if (s == 0) cfg0 = c;
    else cfg1 = c;
    pulse(0, s);
    // moved base must not disturb the running sequence
    cfg0.sequence_base = 32'h0;
    cfg1.sequence_base = 32'h0;
    wait_sig(1);
    check(begun, 2'h1 << s);
  endtask : play
  // skip a period so old and new values never share the window
  task automatic measure;
    wait_sig(0);
    wait_sig(0);
    hi = '{default: 0};
    plen = 0;
    do begin
      foreach (hi[c]) hi[c] += (pwm[c] === 1'b1);
      plen++;
      @(negedge clock_i);
    end while (pe !== 1'b1 && plen < 400);
  endtask : measure
  task automatic halt;
    pulse(2, 0);
    wait_sig(3);
    @(negedge clock_i);
    check(pwm, idle_lv);
    check(running, 1'b0);
  endtask : halt
  task automatic shape(input layout_t ly, input int t, input int e[4]);
    play(1, ly, 0);
    check(done, 2'h2);
    measure();
    foreach (e[c]) check(hi[c], e[c]);
    check(plen, t);
    check(rd_req, 1'b0);
    halt();
  endtask : shape
  initial begin
    repeat (6) @(negedge clock_i);
    srst_i = 1'b0;
    @(negedge clock_i);
    check(running, 1'b0);
    for (n = 0; n < 3; n += 2) begin
      wq = '{16'h8003, 16'h0004};
      play(0, LAYOUT_COMMON, n);
      k = 0;
      for (int i = 0; i < 999 && done === 2'h0; i++) begin
        @(negedge clock_i);
        k += (pe === 1'b1);
      end
      check(done, 2'h1);
      @(negedge clock_i);
      k += (pe === 1'b1);
      check(k, n + 1);
      measure();
      foreach (hi[c]) check(hi[c], 6);
      halt();
      pulse(1, 0);
      repeat (3) @(negedge clock_i);
      check(running, 1'b0);
    end
    slow = 1'b1;
    wq = '{16'h8002, 16'h0005, 16'h8001, 16'h0007};
    shape(LAYOUT_INDIVIDUAL, 10, '{2, 5, 1, 3});
    wq = '{16'h0003, 16'h8006};
    shape(LAYOUT_GROUPED, 10, '{7, 7, 6, 6});
    wq = '{16'h0001, 16'h8002, 16'h0003, 16'h0008};
    shape(WAVE_LAYOUT, 8, '{7, 2, 5, 8});
    manual = 1'b1;
    wq = '{16'h8003, 16'h0004};
    play(0, LAYOUT_COMMON, 5);
    k = done_cnt;
    repeat (3) wait_sig(0);
    check(done_cnt, k);
    pulse(1, 0);
    wait_sig(2);
    // new top lands at the next period end, measure skips that period
    top_v = 15'h000C;
    measure();
    check(hi[0], 8);
    check(plen, 12);
    halt();
    give_verdict();
  end
endmodule : testbench
